// [rtl/cfg_regs_pkg.sv]
// constants for the indexed configuration register bank
// assumes a 10-bit isa-style i/o address and an 8-bit data bus
package cfg_regs_pkg;

   // ==========================================================
   // host ports and register indices
   localparam logic [9:0] INDEX_PORT_ADDR = 10'h3F0;
   localparam logic [9:0] DATA_PORT_ADDR  = 10'h3F1;
   localparam logic [7:0] IDX_PAR_SERIAL  = 8'h01;
   localparam logic [7:0] IDX_SERIAL      = 8'h02;
   localparam logic [7:0] IDX_FLOPPY      = 8'h03;

   // ==========================================================
   // power-up values and the floppy write mask
   localparam logic [7:0] PAR_SERIAL_RESET = 8'h9F;
   localparam logic [7:0] SERIAL_RESET     = 8'hDC;
   localparam logic [7:0] FLOPPY_RESET     = 8'h78;
   localparam logic [7:0] INDEX_RESET      = 8'h00;
   localparam logic [7:0] FLOPPY_WR_MASK   = 8'hFA;

   // ==========================================================
   // field positions
   localparam int PS_PAR_POWER  = 2;
   localparam int PS_PAR_MODE   = 3;
   localparam int PS_IRQ_POL    = 4;
   localparam int PS_SLOT_LO    = 5;
   localparam int PS_LOCK       = 7;
   localparam int SP_S1_EN      = 2;
   localparam int SP_S1_PWR     = 3;
   localparam int SP_S2_LO      = 4;
   localparam int SP_S2_EN      = 6;
   localparam int SP_S2_PWR     = 7;
   localparam int FL_ENHANCED   = 1;
   localparam int FL_OPT0       = 3;
   localparam int FL_OPT1       = 4;
   localparam int FL_FORMAT     = 5;
   localparam int FL_IDENT      = 6;
   localparam int FL_ADDR_OUT   = 7;

   // ==========================================================
   // port base addresses
   localparam logic [9:0] PAR_BASE_1  = 10'h3BC;
   localparam logic [9:0] PAR_BASE_2  = 10'h378;
   localparam logic [9:0] PAR_BASE_3  = 10'h278;
   localparam logic [9:0] SER_BASE_1  = 10'h3F8;
   localparam logic [9:0] SER_BASE_2  = 10'h2F8;
   localparam logic [9:0] THIRD_0     = 10'h338;
   localparam logic [9:0] THIRD_1     = 10'h3E8;
   localparam logic [9:0] THIRD_2     = 10'h2E8;
   localparam logic [9:0] THIRD_3     = 10'h220;
   localparam logic [9:0] FOURTH_0    = 10'h238;
   localparam logic [9:0] FOURTH_1    = 10'h2E8;
   localparam logic [9:0] FOURTH_2    = 10'h2E0;
   localparam logic [9:0] FOURTH_3    = 10'h228;
   localparam logic [9:0] ZERO_BASE   = 10'h000;

   typedef enum logic [1:0] {
      MODE_LEGACY_B,
      MODE_LEGACY_A,
      MODE_RESERVED,
      MODE_PRIMARY
   } fdc_mode_type;

endpackage

// [rtl/cfg_bits_if.sv]
// carries the three setup register values from the bank to the pin mapper
// assumes both ends run on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
interface cfg_bits_if;
   logic [7:0] par_serial;
   logic [7:0] serial;
   logic [7:0] floppy;
   modport src (output par_serial, output serial, output floppy);
   modport dst (input par_serial, input serial, input floppy);
endinterface
`default_nettype wire

// [rtl/cfg_pin_mapper.sv]
// maps setup bits onto interrupt, data-rate and shared address/drive pins
// assumes irq and rate inputs come from logic on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module cfg_pin_mapper
   import cfg_regs_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   // setup values
   cfg_bits_if.dst         cfg,
   // peripheral events
   input  wire logic [3:0] irq_raw_i,
   input  wire logic [1:0] rate_select_value_i,
   input  wire logic       addr_hit_i,
   input  wire logic       shared_pin_i,
   // pins
   output logic [3:0]      irq_out_o,
   output logic [3:0]      irq_oe_n_o,
   output logic            rate_out_lo_o,
   output logic            rate_out_hi_o,
   output logic            rate_oe_n_o,
   output logic            shared_pin_o,
   output logic            shared_pin_oe_n_o,
   output logic            drive2_present_o
);
   logic [1:0] opt;
   logic       pol;
   logic       sh_meta_q;
   logic       sh_sync_q;

   assign pol = cfg.par_serial[PS_IRQ_POL];
   // enhanced mode makes drive options don't-care
   assign opt = cfg.floppy[FL_ENHANCED] ? 2'h0
                : {cfg.floppy[FL_OPT1], cfg.floppy[FL_OPT0]};

   // ==========================================================
   // interrupt pins
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         irq_out_o  <= 4'h0;
         irq_oe_n_o <= 4'h0;
      end else if (pol) begin
         irq_out_o  <= irq_raw_i;
         irq_oe_n_o <= 4'h0;
      end else begin
         irq_out_o  <= 4'h0;
         irq_oe_n_o <= ~irq_raw_i;
      end
   end

   // ==========================================================
   // data-rate pins
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rate_out_hi_o <= 1'b0;
         rate_out_lo_o <= 1'b0;
         rate_oe_n_o   <= 1'b1;
      end else begin
         case (opt)
            2'h1: begin
               // 500 and 250 swap
               rate_out_hi_o <= ~rate_select_value_i[1] ^ rate_select_value_i[0];
               rate_out_lo_o <= rate_select_value_i[0];
               rate_oe_n_o   <= 1'b0;
            end
            2'h3: begin
               rate_out_hi_o <= 1'b0;
               rate_out_lo_o <= 1'b0;
               rate_oe_n_o   <= 1'b1;
            end
            default: begin
               rate_out_hi_o <= rate_select_value_i[1];
               rate_out_lo_o <= rate_select_value_i[0];
               rate_oe_n_o   <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // shared address-output / drive-2 pin
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sh_meta_q <= 1'b0;
         sh_sync_q <= 1'b0;
      end else begin
         sh_meta_q <= shared_pin_i;
         sh_sync_q <= sh_meta_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         shared_pin_o      <= 1'b0;
         shared_pin_oe_n_o <= 1'b1;
         drive2_present_o  <= 1'b0;
      end else begin
         shared_pin_o      <= cfg.floppy[FL_ADDR_OUT] & addr_hit_i;
         shared_pin_oe_n_o <= ~cfg.floppy[FL_ADDR_OUT];
         drive2_present_o  <= ~cfg.floppy[FL_ADDR_OUT] & sh_sync_q;
      end
   end

   chk_rate_swap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (opt == 2'h1 && rate_select_value_i == 2'h0)
      |=> (rate_out_hi_o && !rate_out_lo_o && !rate_oe_n_o))
      else $error("rate pins wrong for 500 with option 0");
   chk_rate_input: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (opt == 2'h3) |=> rate_oe_n_o)
      else $error("rate pins driven while set as inputs");
   chk_irq_float: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!pol && !irq_raw_i[0]) |=> irq_oe_n_o[0])
      else $error("idle active-low irq not floated");
   chk_irq_high: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      pol |=> (irq_out_o == $past(irq_raw_i) && irq_oe_n_o == 4'h0))
      else $error("active-high irq not following event");
endmodule
`default_nettype wire

// [rtl/cfg_reg_bank.sv]
// indexed configuration bank: index port, data port, three setup registers
// assumes isa pins are asynchronous and config mode comes from on-clock logic
//
// What this block does
// - setup register one at index 01H, config mode only, power-up 9FH
// - bits 1:0 pick parallel base: off, 3BCH, 378H, 278H default
// - bit 2 set powers parallel port, clear puts it in low power
// - bit 3 set gives printer mode, clear enables extended modes
// - bit 4 picks irq polarity: high/driven or low/floating idle
// - bits 6:5 pick third/fourth serial slot address pairs
// - bit 7 set allows config register access, clear blocks it
// - lock bit once cleared cannot be set again except by hard reset
// - serial setup register at index 02H, config mode only, power-up DCH
// - bits 1:0 place primary serial port: 3F8H, 2F8H, third, fourth
// - bit 2 enables primary serial port
// - bit 3 clear powers down primary serial port
// - bits 5:4 place secondary port, same mapping, default 2F8H
// - bit 6 enables secondary serial port
// - bit 7 clear powers down secondary serial port
// - floppy setup register at index 03H, config mode only, power-up 78H
// - floppy bits 0 and 2 read back zero
// - floppy bit 1 selects enhanced mode; drive options then ignored
// - floppy bits 3,4 map rate select to rate pins, both one
// - identity and format bits choose floppy interface mode
// - floppy bit 7 makes shared pin address output, else drive-2 input
// - rate pins: direct, 500/250 swapped, or inputs per drive options
// - index written at 3F0H, selected register accessed at 3F1H
// - setup registers load defaults only at power-up, not on bus reset
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_bank
   import cfg_regs_pkg::*;
(
   // clock and power-up reset
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_i,
   // isa-style host pins
   input  wire logic [9:0]                  io_addr_i,
   input  wire logic [7:0]                  io_data_i,
   input  wire logic                        io_wr_n_i,
   input  wire logic                        io_rd_n_i,
   input  wire logic                        bus_reset_i,
   output logic [7:0]                       io_data_o,
   output logic                             io_data_oe_n_o,
   // from configuration-mode entry logic
   input  wire logic                        config_mode_i,
   // peripheral side inputs
   input  wire logic [3:0]                  irq_raw_i,
   input  wire logic [1:0]                  rate_select_value_i,
   input  wire logic                        addr_hit_i,
   input  wire logic                        shared_pin_i,
   // parallel port control
   output logic [9:0]                       par_base_o,
   output logic                             par_enable_o,
   output logic                             par_powered_o,
   output logic                             par_printer_mode_o,
   // serial port control
   output logic [9:0]                       ser1_base_o,
   output logic                             ser1_enable_o,
   output logic                             ser1_powered_o,
   output logic [9:0]                       ser2_base_o,
   output logic                             ser2_enable_o,
   output logic                             ser2_powered_o,
   // floppy control
   output logic                             floppy_enhanced_o,
   output cfg_regs_pkg::fdc_mode_type       floppy_if_mode_o,
   // pins
   output logic [3:0]                       irq_out_o,
   output logic [3:0]                       irq_oe_n_o,
   output logic                             rate_out_lo_o,
   output logic                             rate_out_hi_o,
   output logic                             rate_oe_n_o,
   output logic                             shared_pin_o,
   output logic                             shared_pin_oe_n_o,
   output logic                             drive2_present_o
);
   import cfg_regs_pkg::*;

   // ==========================================================
   // address decode helpers
   function automatic logic [9:0] slot_base(input logic [1:0] sel,
                                            input logic [1:0] pair,
                                            input logic       fourth);
      logic [9:0] third_a;
      logic [9:0] fourth_a;
      case (pair)
         2'h0: begin
            third_a  = THIRD_0;
            fourth_a = FOURTH_0;
         end
         2'h1: begin
            third_a  = THIRD_1;
            fourth_a = FOURTH_1;
         end
         2'h2: begin
            third_a  = THIRD_2;
            fourth_a = FOURTH_2;
         end
         default: begin
            third_a  = THIRD_3;
            fourth_a = FOURTH_3;
         end
      endcase
      if (fourth) begin
         return fourth_a;
      end
      case (sel)
         2'h0:    return SER_BASE_1;
         2'h1:    return SER_BASE_2;
         2'h2:    return third_a;
         default: return fourth_a;
      endcase
   endfunction

   function automatic logic [9:0] serial_base(input logic [1:0] sel,
                                              input logic [1:0] pair);
      return (sel == 2'h3) ? slot_base(sel, pair, 1'b1) : slot_base(sel, pair, 1'b0);
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [9:0] addr_m_q, addr_s_q;
   logic [7:0] data_m_q, data_s_q;
   logic [3:0] ctl_m_q, ctl_s_q;
   logic       wr_n_d1_q;
   logic       rd_n_d1_q;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         addr_m_q <= 10'h000;
         addr_s_q <= 10'h000;
         data_m_q <= 8'h00;
         data_s_q <= 8'h00;
         ctl_m_q  <= 4'h3;
         ctl_s_q  <= 4'h3;
      end else begin
         addr_m_q <= io_addr_i;
         addr_s_q <= addr_m_q;
         data_m_q <= io_data_i;
         data_s_q <= data_m_q;
         ctl_m_q  <= {2'h0, io_rd_n_i, io_wr_n_i} | {1'b0, bus_reset_i, 2'h0};
         ctl_s_q  <= ctl_m_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_n_d1_q <= 1'b1;
         rd_n_d1_q <= 1'b1;
      end else begin
         wr_n_d1_q <= ctl_s_q[0];
         rd_n_d1_q <= ctl_s_q[1];
      end
   end

   logic wr_take;
   logic rd_take;
   logic bus_rst;
   logic at_index;
   logic at_data;
   assign bus_rst  = ctl_s_q[2];
   // no register write lands while the bus reset is asserted
   assign wr_take  = wr_n_d1_q & ~ctl_s_q[0] & ~bus_rst;
   assign rd_take  = rd_n_d1_q & ~ctl_s_q[1];
   assign at_index = config_mode_i && (addr_s_q == INDEX_PORT_ADDR);
   assign at_data  = config_mode_i && (addr_s_q == DATA_PORT_ADDR);

   // ==========================================================
   // index register and access gate
   logic [7:0] index_q;
   logic [7:0] par_serial_q;
   logic [7:0] serial_q;
   logic [7:0] floppy_q;
   logic       gate_open;
   logic       wr_ps;
   logic       wr_sp;
   logic       wr_fl;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || bus_rst) begin
         index_q <= INDEX_RESET;
      end else if (wr_take && at_index) begin
         index_q <= data_s_q;
      end
   end

   assign gate_open = at_data && par_serial_q[PS_LOCK];
   assign wr_ps     = wr_take && gate_open && (index_q == IDX_PAR_SERIAL);
   assign wr_sp     = wr_take && gate_open && (index_q == IDX_SERIAL);
   assign wr_fl     = wr_take && gate_open && (index_q == IDX_FLOPPY);

   // ==========================================================
   // setup registers, cleared only by power-up reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         par_serial_q <= PAR_SERIAL_RESET;
      end else if (wr_ps) begin
         // lock can only fall
         par_serial_q <= {data_s_q[PS_LOCK] & par_serial_q[PS_LOCK], data_s_q[6:0]};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         serial_q <= SERIAL_RESET;
      end else if (wr_sp) begin
         serial_q <= data_s_q;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         floppy_q <= FLOPPY_RESET;
      end else if (wr_fl) begin
         floppy_q <= data_s_q & FLOPPY_WR_MASK;
      end
   end

   // ==========================================================
   // read path
   logic [7:0] rd_value;
   logic       rd_hit;
   always_comb begin
      rd_hit   = gate_open;
      rd_value = 8'h00;
      case (index_q)
         IDX_PAR_SERIAL: rd_value = par_serial_q;
         IDX_SERIAL:     rd_value = serial_q;
         IDX_FLOPPY:     rd_value = floppy_q;
         default:        rd_hit   = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || ctl_s_q[1]) begin
         io_data_o      <= 8'h00;
         io_data_oe_n_o <= 1'b1;
      end else if (rd_take && rd_hit) begin
         io_data_o      <= rd_value;
         io_data_oe_n_o <= 1'b0;
      end
   end

   // ==========================================================
   // decoded controls
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         par_base_o         <= ZERO_BASE;
         par_enable_o       <= 1'b0;
         par_powered_o      <= 1'b0;
         par_printer_mode_o <= 1'b0;
      end else begin
         case (par_serial_q[1:0])
            2'h1:    par_base_o <= PAR_BASE_1;
            2'h2:    par_base_o <= PAR_BASE_2;
            2'h3:    par_base_o <= PAR_BASE_3;
            default: par_base_o <= ZERO_BASE;
         endcase
         par_enable_o       <= par_serial_q[1:0] != 2'h0;
         par_powered_o      <= par_serial_q[PS_PAR_POWER];
         par_printer_mode_o <= par_serial_q[PS_PAR_MODE];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ser1_base_o    <= ZERO_BASE;
         ser1_enable_o  <= 1'b0;
         ser1_powered_o <= 1'b0;
         ser2_base_o    <= ZERO_BASE;
         ser2_enable_o  <= 1'b0;
         ser2_powered_o <= 1'b0;
      end else begin
         ser1_base_o    <= serial_base(serial_q[1:0], par_serial_q[6:5]);
         ser1_enable_o  <= serial_q[SP_S1_EN];
         ser1_powered_o <= serial_q[SP_S1_PWR];
         ser2_base_o    <= serial_base(serial_q[5:4], par_serial_q[6:5]);
         ser2_enable_o  <= serial_q[SP_S2_EN];
         ser2_powered_o <= serial_q[SP_S2_PWR];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         floppy_enhanced_o <= 1'b0;
         floppy_if_mode_o  <= MODE_PRIMARY;
      end else begin
         floppy_enhanced_o <= floppy_q[FL_ENHANCED];
         floppy_if_mode_o  <= fdc_mode_type'({floppy_q[FL_IDENT], floppy_q[FL_FORMAT]});
      end
   end

   // ==========================================================
   // pin mapping
   cfg_bits_if bits ();
   assign bits.par_serial = par_serial_q;
   assign bits.serial     = serial_q;
   assign bits.floppy     = floppy_q;

   cfg_pin_mapper u_pins (
      .ref_clk_i           (ref_clk_i),
      .rst_i               (rst_i),
      .cfg                 (bits),
      .irq_raw_i           (irq_raw_i),
      .rate_select_value_i (rate_select_value_i),
      .addr_hit_i          (addr_hit_i),
      .shared_pin_i        (shared_pin_i),
      .irq_out_o           (irq_out_o),
      .irq_oe_n_o          (irq_oe_n_o),
      .rate_out_lo_o       (rate_out_lo_o),
      .rate_out_hi_o       (rate_out_hi_o),
      .rate_oe_n_o         (rate_oe_n_o),
      .shared_pin_o        (shared_pin_o),
      .shared_pin_oe_n_o   (shared_pin_oe_n_o),
      .drive2_present_o    (drive2_present_o)
   );

   // ==========================================================
   // checks
   chk_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !par_serial_q[PS_LOCK] |=> !par_serial_q[PS_LOCK])
      else $error("lock bit set again by software");
   chk_locked_frozen: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !par_serial_q[PS_LOCK] |=> ($stable(serial_q) && $stable(floppy_q)))
      else $error("register changed while access locked");
   chk_bus_reset_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bus_rst |=> ($stable(par_serial_q) && $stable(serial_q) && $stable(floppy_q)))
      else $error("bus reset disturbed setup registers");
   chk_floppy_rsvd: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      floppy_q[0] == 1'b0 && floppy_q[2] == 1'b0)
      else $error("reserved floppy bits not zero");
   chk_mode_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !config_mode_i |=> ($stable(serial_q) && ($stable(index_q) || $past(bus_rst))))
      else $error("access outside configuration mode");
   chk_read_data: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rd_take && rd_hit && !ctl_s_q[1]) |=> (!io_data_oe_n_o && io_data_o == $past(rd_value)))
      else $error("read returned wrong value");
   chk_par_base: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (par_serial_q[1:0] == 2'h3) ##1 $stable(par_serial_q) |-> par_base_o == PAR_BASE_3)
      else $error("parallel base decode wrong");
   chk_ser_third: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (serial_q[1:0] == 2'h2 && par_serial_q[6:5] == 2'h1) |=> ser1_base_o == THIRD_1)
      else $error("primary serial third-slot decode wrong");
   chk_ser2_fourth: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (serial_q[5:4] == 2'h3 && par_serial_q[6:5] == 2'h3) |=> ser2_base_o == FOURTH_3)
      else $error("secondary serial fourth-slot decode wrong");

   cov_lock_clear: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_ps && !data_s_q[PS_LOCK]);
   cov_floppy_write: cover property (@(posedge ref_clk_i) disable iff (rst_i) wr_fl);
   cov_read_serial: cover property (@(posedge ref_clk_i) disable iff (rst_i)
      rd_take && rd_hit && index_q == IDX_SERIAL);
endmodule
`default_nettype wire

// [bench/host_model.sv]
// host model: isa-style master on the index/data port pair
// assumes callers enter its task at a falling edge of ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input  wire logic       ref_clk_i,
   // bus
   output logic [9:0]      io_addr_o,
   output logic [7:0]      io_data_o,
   output logic            io_wr_n_o,
   output logic            io_rd_n_o,
   input  wire logic [7:0] io_rdata_i,
   input  wire logic       io_oe_n_i
);
   initial begin
      io_addr_o = 10'h000;
      io_data_o = 8'h00;
      io_wr_n_o = 1'b1;
      io_rd_n_o = 1'b1;
   end
   // ==========================================================
   // one strobe; q is 100H when read data is not driven
   task automatic cyc(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [8:0] q);
      io_addr_o = a;
      io_data_o = d;
      repeat (5) @(negedge ref_clk_i);
      if (wr) io_wr_n_o = 1'b0;
      else io_rd_n_o = 1'b0;
      repeat (6) @(negedge ref_clk_i);
      q = (io_oe_n_i !== 1'b0) ? 9'h100 : {1'b0, io_rdata_i};
      io_wr_n_o = 1'b1;
      io_rd_n_o = 1'b1;
      io_data_o = ~d; // released bus shows no stale value
      repeat (6) @(negedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
// bench for the configuration register bank
// assumes cfg_regs_pkg and the bank compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cfg_regs_pkg::*;
   logic clk = 1'b0, rst = 1'b1, brst = 1'b0, cfgm = 1'b1;
   logic [9:0] a, pb, s1, s2;
   logic [7:0] d, q;
   logic wn, rn, oe;
   logic [3:0] irq = 4'h0;
   logic [1:0] rs = 2'h0;
   logic ah = 1'b0, sp = 1'b0;
   wire [15:0] po;
   wire [7:0] iq;
   int bad_count = 0, compares = 0;
   always #12.5 clk = ~clk;
   host_model host_model_i (.ref_clk_i(clk), .io_addr_o(a), .io_data_o(d), .io_wr_n_o(wn),
      .io_rd_n_o(rn), .io_rdata_i(q), .io_oe_n_i(oe));
   cfg_reg_bank cfg_reg_bank_i (.ref_clk_i(clk), .rst_i(rst), .io_addr_i(a), .io_data_i(d),
      .io_wr_n_i(wn), .io_rd_n_i(rn), .bus_reset_i(brst), .io_data_o(q), .io_data_oe_n_o(oe),
      .config_mode_i(cfgm), .irq_raw_i(irq), .rate_select_value_i(rs), .addr_hit_i(ah),
      .shared_pin_i(sp), .par_base_o(pb), .par_enable_o(po[0]), .par_powered_o(po[1]),
      .par_printer_mode_o(po[2]), .ser1_base_o(s1), .ser1_enable_o(po[3]),
      .ser1_powered_o(po[4]), .ser2_base_o(s2), .ser2_enable_o(po[5]),
      .ser2_powered_o(po[6]), .floppy_enhanced_o(po[7]), .floppy_if_mode_o(po[15:14]),
      .irq_out_o(iq[3:0]), .irq_oe_n_o(iq[7:4]), .rate_out_lo_o(po[8]),
      .rate_out_hi_o(po[9]), .rate_oe_n_o(po[10]), .shared_pin_o(po[11]),
      .shared_pin_oe_n_o(po[12]), .drive2_present_o(po[13]));
   // ==========================================================
   // helpers
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic put(input logic [7:0] i, input logic [7:0] v);
      logic [8:0] r;
      host_model_i.cyc(1'b1, INDEX_PORT_ADDR, i, r);
      host_model_i.cyc(1'b1, DATA_PORT_ADDR, v, r);
   endtask
   task automatic get(input logic [7:0] i, input logic [8:0] e);
      logic [8:0] r;
      host_model_i.cyc(1'b1, INDEX_PORT_ADDR, i, r);
      host_model_i.cyc(1'b0, DATA_PORT_ADDR, 8'h00, r);
      chk("rdata", {1'b0, e}, {1'b0, r});
   endtask
   task automatic close_out;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_defaults;
      get(IDX_PAR_SERIAL, 9'h09F);
      get(IDX_SERIAL, 9'h0DC);
      get(IDX_FLOPPY, 9'h078);
      chk("par_base", 10'h278, pb);
      chk("ser1_base", 10'h3F8, s1);
      chk("ser2_base", 10'h2F8, s2);
      chk("ctl_pins", 16'hD47F, po);
      chk("irq_pins", 8'h00, iq);
   endtask
   task automatic t_pins;
      irq = 4'h6;
      sp = 1'b1;
      ah = 1'b1;
      put(IDX_FLOPPY, 8'h08);
      chk("ctl_pins", 16'h327F, po);
      chk("irq_pins", 8'h06, iq);
      rs = 2'h2;
      repeat (2) @(negedge clk);
      chk("ctl_pins", 16'h307F, po);
      put(IDX_PAR_SERIAL, 8'h8F);
      put(IDX_FLOPPY, 8'h80);
      chk("ctl_pins", 16'h0A7F, po);
      chk("irq_pins", 8'h90, iq);
      chk("ser1_base", 10'h238, s1);
   endtask
   task automatic t_par_base;
      logic [9:0] e [4] = '{10'h000, 10'h3BC, 10'h378, 10'h278};
      for (int k = 0; k < 4; k++) begin
         put(IDX_PAR_SERIAL, 8'h9C | 8'(k));
         chk("par_base", e[k], pb);
      end
   endtask
   task automatic t_slots;
      put(IDX_PAR_SERIAL, 8'hFF);
      put(IDX_SERIAL, 8'hDE);
      chk("ser1_base", 10'h220, s1);
      put(IDX_SERIAL, 8'hDF);
      chk("ser1_base", 10'h228, s1);
   endtask
   task automatic t_floppy_bus_reset;
      put(IDX_FLOPPY, 8'hFF);
      get(IDX_FLOPPY, 9'h0FA);
      brst = 1'b1;
      repeat (4) @(negedge clk);
      brst = 1'b0;
      get(IDX_FLOPPY, 9'h0FA);
      cfgm = 1'b0;
      get(IDX_PAR_SERIAL, 9'h100);
      cfgm = 1'b1;
   endtask
   task automatic t_lock;
      put(IDX_PAR_SERIAL, 8'h1F);
      get(IDX_SERIAL, 9'h100);
      put(IDX_PAR_SERIAL, 8'h9F);
      get(IDX_PAR_SERIAL, 9'h100);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      get(IDX_PAR_SERIAL, 9'h09F);
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_defaults();
      t_par_base();
      t_slots();
      t_floppy_bus_reset();
      t_pins();
      t_lock();
      close_out();
   end
   initial begin
      #(25 * 20000);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
